// File: hdl/tcct_pkg.sv
// Shared constants and types of the two-channel capture/compare timer.
// Assumes a 16-bit register port with 8-bit word addresses.
package tcct_pkg;
    localparam int CNT_W = 16;
    localparam int NCH = 2;
    localparam logic [7:0] A_STAT = 8'h00;
    localparam logic [7:0] A_COUNT = 8'h01;
    localparam logic [7:0] A_MOD = 8'h02;
    localparam logic [7:0] A_CH0_CTL = 8'h03;
    localparam logic [7:0] A_CH0_VAL = 8'h04;
    localparam logic [7:0] A_CH1_CTL = 8'h05;
    localparam logic [7:0] A_CH1_VAL = 8'h06;
    localparam int ST_FLAG = 7;
    localparam int ST_IE = 6;
    localparam int ST_HALT = 5;
    localparam int ST_RST = 4;
    localparam int ST_PS_LSB = 0;
    localparam int CC_FLAG = 7;
    localparam int CC_IE = 6;
    localparam int CC_MSHI = 5;
    localparam int CC_MSLO = 4;
    localparam int CC_ELHI = 3;
    localparam int CC_ELLO = 2;
    localparam int CC_WT = 1;
    localparam logic HALT_RST = 1'h1;
    localparam logic [2:0] PS_RST = 3'h0;
    localparam logic [2:0] PS_EXT = 3'h7;
    localparam logic [15:0] MOD_RST = 16'hFFFF;
    localparam logic [15:0] VAL_RST = 16'h0000;
    localparam logic PIN_RST = 1'h1;
    typedef enum logic [1:0] {CM_OFF, CM_CAPTURE, CM_COMPARE, CM_BUFFERED} tcct_chmode_t;
endpackage

// File: hdl/tcct_chan_if.sv
// Link between the timer core and one channel.
// Assumes one bus clock shared by both ends.
`timescale 1ns/100ps
`default_nettype none
interface tcct_chan_if;
    logic [tcct_pkg::CNT_W-1:0] count;
    logic tick;
    logic wrap;
    logic halt;
    logic ms_hi;
    logic ms_lo;
    logic [1:0] edge_sel;
    logic wrap_toggle;
    logic val_wr;
    logic [tcct_pkg::CNT_W-1:0] val_wdata;
    logic pin_in;
    logic [tcct_pkg::CNT_W-1:0] val;
    logic event_p;
    logic pin_out;
    logic pin_oe;
    modport tmr (output count, tick, wrap, halt, ms_hi, ms_lo, edge_sel, wrap_toggle,
        val_wr, val_wdata, pin_in, input val, event_p, pin_out, pin_oe);
    modport ch (input count, tick, wrap, halt, ms_hi, ms_lo, edge_sel, wrap_toggle,
        val_wr, val_wdata, pin_in, output val, event_p, pin_out, pin_oe);
endinterface
`default_nettype wire

// File: hdl/tcct_channel.sv
// One capture/compare channel: pin sync, capture, compare and pin drive.
// Assumes count, tick and wrap come from the core on the same clock.
`timescale 1ns/100ps
`default_nettype none
module tcct_channel (
    input wire logic clk, // Bus clock
    input wire logic rst_n, // Synchronised reset, active low
    tcct_chan_if.ch chan // Core link
);
    logic pin_s1_q, pin_s2_q, pin_s3_q;
    logic [15:0] val_q, active_q;
    logic pin_out_q, pin_oe_q, event_q;
    logic rise, fall, cap_hit, cmp_hit, outmode, drive;
    tcct_pkg::tcct_chmode_t mode;

    always_comb
    begin
        if (chan.ms_hi)
            mode = tcct_pkg::CM_BUFFERED;
        else if (chan.ms_lo)
            mode = tcct_pkg::CM_COMPARE;
        else if (chan.edge_sel != 2'h0)
            mode = tcct_pkg::CM_CAPTURE;
        else
            mode = tcct_pkg::CM_OFF;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_s1_q <= 1'h0;
            pin_s2_q <= 1'h0;
            pin_s3_q <= 1'h0;
        end
        else
        begin
            pin_s1_q <= chan.pin_in;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    assign rise = pin_s2_q & ~pin_s3_q;
    assign fall = ~pin_s2_q & pin_s3_q;
    // Captures are held off while the counter is halted
    assign cap_hit = (mode == tcct_pkg::CM_CAPTURE) && !chan.halt
        && ((chan.edge_sel[0] && rise) || (chan.edge_sel[1] && fall));
    assign outmode = (mode == tcct_pkg::CM_COMPARE) || (mode == tcct_pkg::CM_BUFFERED);
    assign cmp_hit = outmode && chan.tick && (chan.count == active_q);
    assign drive = outmode && (chan.edge_sel != 2'h0);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            val_q <= tcct_pkg::VAL_RST;
        else if (cap_hit)
            val_q <= chan.count;
        else if (chan.val_wr)
            val_q <= chan.val_wdata;
    end

    // Buffered mode takes the new compare value only at counter wrap, avoiding glitched periods
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            active_q <= tcct_pkg::VAL_RST;
        else if (mode == tcct_pkg::CM_BUFFERED)
        begin
            if (chan.wrap)
                active_q <= val_q;
        end
        else if (chan.val_wr)
            active_q <= chan.val_wdata;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pin_out_q <= tcct_pkg::PIN_RST;
        else if (chan.edge_sel == 2'h0)
            pin_out_q <= ~chan.ms_lo;
        else if (drive && chan.wrap && chan.wrap_toggle)
            pin_out_q <= ~pin_out_q;
        else if (drive && cmp_hit)
        begin
            case (chan.edge_sel)
                2'h1: pin_out_q <= ~pin_out_q;
                2'h2: pin_out_q <= 1'h0;
                2'h3: pin_out_q <= 1'h1;
                default: pin_out_q <= pin_out_q;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_oe_q <= 1'h0;
            event_q <= 1'h0;
        end
        else
        begin
            pin_oe_q <= drive;
            event_q <= cap_hit | cmp_hit;
        end
    end

    assign chan.val = val_q;
    assign chan.event_p = event_q;
    assign chan.pin_out = pin_out_q;
    assign chan.pin_oe = pin_oe_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_disconnect;
        chan.edge_sel == 2'h0 |=> !pin_oe_q;
    endproperty
    a_disconnect: assert property (p_disconnect) else $error("pin driven while off");
    property p_preset;
        chan.edge_sel == 2'h0 |=> pin_out_q == !$past(chan.ms_lo);
    endproperty
    a_preset: assert property (p_preset) else $error("wrong preset level");
    property p_no_cap_halted;
        mode == tcct_pkg::CM_CAPTURE && chan.halt |=> !event_q;
    endproperty
    a_no_cap_halted: assert property (p_no_cap_halted) else $error("capture while halted");
    property p_rise_cap;
        mode == tcct_pkg::CM_CAPTURE && chan.edge_sel == 2'h1 && !chan.halt && rise
            |=> event_q && val_q == $past(chan.count);
    endproperty
    a_rise_cap: assert property (p_rise_cap) else $error("rising edge not captured");
    property p_wrap_prio;
        drive && chan.wrap && chan.wrap_toggle |=> pin_out_q != $past(pin_out_q);
    endproperty
    a_wrap_prio: assert property (p_wrap_prio) else $error("wrap toggle lost");
    property p_set_cmp;
        drive && cmp_hit && chan.edge_sel == 2'h3 && !(chan.wrap && chan.wrap_toggle)
            |=> pin_out_q;
    endproperty
    a_set_cmp: assert property (p_set_cmp) else $error("set on compare failed");
endmodule // tcct_channel
`default_nettype wire

// File: hdl/tcct_timer.sv
// Two-channel capture/compare timer core with register port.
// Assumes a one-cycle strobe register master on clk; pins are asynchronous.
`timescale 1ns/100ps
`default_nettype none
module tcct_timer (
    input wire logic clk, // Bus clock, 125 MHz
    input wire logic rstn, // Asynchronous reset, active low
    input wire logic [7:0] addr, // Register word address
    input wire logic [15:0] wdata, // Write data
    input wire logic wr, // Write strobe
    input wire logic rd, // Read strobe
    output logic [15:0] rdata_q, // Read data, cycle after rd
    input wire logic ext_timer_clock_pin, // External counter clock
    input wire logic [1:0] channel_pin_in, // Channel pin levels
    output logic [1:0] channel_pin_out, // Channel pin drive level
    output logic [1:0] channel_pin_oe, // Channel pin drive enable
    output logic irq_q // Interrupt request, active high
);
    localparam int NCH = tcct_pkg::NCH;

    logic rst_s1_q, rst_n_q;
    logic ext_s1_q, ext_s2_q, ext_s3_q;
    logic [5:0] presc_q;
    logic [6:0] presc_lim;
    logic [15:0] count_q, mod_q;
    logic flag_q, arm_q, ie_q, halt_q;
    logic [2:0] ps_q;
    logic tick, wrap, wr_stat, rd_stat, rst_cmd;
    logic [NCH-1:0] chflag_q, charm_q, ch_ie_q, ch_mshi_q, ch_mslo_q, ch_wt_q;
    logic [1:0] ch_el_q [NCH];
    logic [NCH-1:0] wr_ctl, rd_ctl, ch_ev;
    logic [15:0] ch_val [NCH];
    logic [15:0] rmux;

    function automatic logic [7:0] ch_ctl_addr(input int i);
        return (i == 0) ? tcct_pkg::A_CH0_CTL : tcct_pkg::A_CH1_CTL;
    endfunction

    function automatic logic [7:0] ch_val_addr(input int i);
        return (i == 0) ? tcct_pkg::A_CH0_VAL : tcct_pkg::A_CH1_VAL;
    endfunction

    // Reset asserts at once but releases through two flops
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_s1_q <= 1'h0;
            rst_n_q <= 1'h0;
        end
        else
        begin
            rst_s1_q <= 1'h1;
            rst_n_q <= rst_s1_q;
        end
    end

    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            ext_s1_q <= 1'h0;
            ext_s2_q <= 1'h0;
            ext_s3_q <= 1'h0;
        end
        else
        begin
            ext_s1_q <= ext_timer_clock_pin;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
        end
    end

    assign wr_stat = wr && (addr == tcct_pkg::A_STAT);
    assign rd_stat = rd && (addr == tcct_pkg::A_STAT);
    assign rst_cmd = wr_stat && wdata[tcct_pkg::ST_RST];

    always_comb
    begin
        for (int i = 0; i < NCH; i++)
        begin
            wr_ctl[i] = wr && (addr == ch_ctl_addr(i));
            rd_ctl[i] = rd && (addr == ch_ctl_addr(i));
        end
    end

    // Divide by 2^ps for ps 0..6; ps 7 follows the external pin's rising edges
    assign presc_lim = 7'(7'h01 << ps_q) - 7'h01;
    always_comb
    begin
        if (halt_q)
            tick = 1'h0;
        else if (ps_q == tcct_pkg::PS_EXT)
            tick = ext_s2_q & ~ext_s3_q;
        else
            // Compare with >= so lowering the prescale never lets the divider run past its limit
            tick = (presc_q >= presc_lim[5:0]);
    end
    assign wrap = tick && (count_q == mod_q);

    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            presc_q <= 6'h00;
        else if (rst_cmd)
            presc_q <= 6'h00;
        else if (!halt_q && ps_q != tcct_pkg::PS_EXT)
            presc_q <= tick ? 6'h00 : presc_q + 6'h01;
    end

    // Modulo FFFF gives free-running operation
    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            count_q <= 16'h0000;
        else if (rst_cmd)
            count_q <= 16'h0000;
        else if (wrap)
            count_q <= 16'h0000;
        else if (tick)
            count_q <= count_q + 16'h0001;
    end

    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            mod_q <= tcct_pkg::MOD_RST;
        else if (wr && addr == tcct_pkg::A_MOD)
            mod_q <= wdata;
    end

    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            ie_q <= 1'h0;
            halt_q <= tcct_pkg::HALT_RST;
            ps_q <= tcct_pkg::PS_RST;
        end
        else if (wr_stat)
        begin
            ie_q <= wdata[tcct_pkg::ST_IE];
            halt_q <= wdata[tcct_pkg::ST_HALT];
            ps_q <= wdata[tcct_pkg::ST_PS_LSB +: 3];
        end
    end

    // A wrap disarms the clear, so a zero write after it is ignored
    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            arm_q <= 1'h0;
        else if (wrap || wr_stat)
            arm_q <= 1'h0;
        else if (rd_stat && flag_q)
            arm_q <= 1'h1;
    end

    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            flag_q <= 1'h0;
        else if (wrap)
            flag_q <= 1'h1;
        else if (wr_stat && !wdata[tcct_pkg::ST_FLAG] && arm_q)
            flag_q <= 1'h0;
    end

    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            ch_ie_q <= '0;
            ch_mshi_q <= '0;
            ch_mslo_q <= '0;
            ch_wt_q <= '0;
            for (int i = 0; i < NCH; i++)
                ch_el_q[i] <= 2'h0;
        end
        else
        begin
            for (int i = 0; i < NCH; i++)
            begin
                if (wr_ctl[i])
                begin
                    ch_ie_q[i] <= wdata[tcct_pkg::CC_IE];
                    ch_mshi_q[i] <= wdata[tcct_pkg::CC_MSHI];
                    ch_mslo_q[i] <= wdata[tcct_pkg::CC_MSLO];
                    ch_el_q[i] <= wdata[tcct_pkg::CC_ELLO +: 2];
                    ch_wt_q[i] <= wdata[tcct_pkg::CC_WT];
                end
            end
        end
    end

    // Channel flags share the read-then-write-zero clear; a new event wins
    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            chflag_q <= '0;
            charm_q <= '0;
        end
        else
        begin
            for (int i = 0; i < NCH; i++)
            begin
                if (ch_ev[i] || wr_ctl[i])
                    charm_q[i] <= 1'h0;
                else if (rd_ctl[i] && chflag_q[i])
                    charm_q[i] <= 1'h1;
                if (ch_ev[i])
                    chflag_q[i] <= 1'h1;
                else if (wr_ctl[i] && !wdata[tcct_pkg::CC_FLAG] && charm_q[i])
                    chflag_q[i] <= 1'h0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            irq_q <= 1'h0;
        else
            irq_q <= (flag_q & ie_q) | (|(chflag_q & ch_ie_q));
    end

    for (genvar g = 0; g < NCH; g++)
    begin : g_ch
        tcct_chan_if cif();
        assign cif.count = count_q;
        assign cif.tick = tick;
        assign cif.wrap = wrap;
        assign cif.halt = halt_q;
        assign cif.ms_hi = ch_mshi_q[g];
        assign cif.ms_lo = ch_mslo_q[g];
        assign cif.edge_sel = ch_el_q[g];
        assign cif.wrap_toggle = ch_wt_q[g];
        assign cif.val_wr = wr && (addr == ch_val_addr(g));
        assign cif.val_wdata = wdata;
        assign cif.pin_in = channel_pin_in[g];
        tcct_channel u_chan (
            .clk(clk),
            .rst_n(rst_n_q),
            .chan(cif.ch)
        );
        assign ch_ev[g] = cif.event_p;
        assign ch_val[g] = cif.val;
        assign channel_pin_out[g] = cif.pin_out;
        assign channel_pin_oe[g] = cif.pin_oe;
    end

    always_comb
    begin
        rmux = 16'h0000;
        if (addr == tcct_pkg::A_STAT)
            rmux = {8'h00, flag_q, ie_q, halt_q, 1'h0, 1'h0, ps_q};
        else if (addr == tcct_pkg::A_COUNT)
            rmux = count_q;
        else if (addr == tcct_pkg::A_MOD)
            rmux = mod_q;
        for (int i = 0; i < NCH; i++)
        begin
            if (addr == ch_ctl_addr(i))
                rmux = {8'h00, chflag_q[i], ch_ie_q[i], ch_mshi_q[i], ch_mslo_q[i],
                    ch_el_q[i], ch_wt_q[i], 1'h0};
            else if (addr == ch_val_addr(i))
                rmux = ch_val[i];
        end
    end

    always_ff @(posedge clk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            rdata_q <= 16'h0000;
        else
            rdata_q <= rd ? rmux : 16'h0000;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n_q);

    sequence s_read_armed;
        rd_stat && flag_q && !wrap;
    endsequence
    sequence s_zero_write;
        wr_stat && !wdata[tcct_pkg::ST_FLAG] && !wrap;
    endsequence

    property p_clear_seq;
        s_read_armed ##1 (!wrap && !wr_stat) ##1 s_zero_write |=> !flag_q;
    endproperty
    a_clear_seq: assert property (p_clear_seq) else $error("flag not cleared");
    property p_wrap_keeps;
        wrap |=> !arm_q && flag_q;
    endproperty
    a_wrap_keeps: assert property (p_wrap_keeps) else $error("wrap left clear armed");
    property p_write_one;
        wr_stat && wdata[tcct_pkg::ST_FLAG] && !flag_q && !wrap |=> !flag_q;
    endproperty
    a_write_one: assert property (p_write_one) else $error("writing one set the flag");
    property p_wrap_flag;
        wrap |=> flag_q;
    endproperty
    a_wrap_flag: assert property (p_wrap_flag) else $error("wrap did not set flag");
    property p_irq;
        flag_q && ie_q |=> irq_q;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not requested");
    property p_halt;
        halt_q && !rst_cmd |=> $stable(count_q);
    endproperty
    a_halt: assert property (p_halt) else $error("counter moved while halted");
    property p_rst_bit;
        rst_cmd |=> count_q == 16'h0000 && presc_q == 6'h00;
    endproperty
    a_rst_bit: assert property (p_rst_bit) else $error("counter reset failed");
    property p_wrap_zero;
        wrap && !rst_cmd |=> count_q == 16'h0000;
    endproperty
    a_wrap_zero: assert property (p_wrap_zero) else $error("no return to zero");
    property p_count_up;
        tick && !wrap && !rst_cmd |=> count_q == $past(count_q) + 16'h0001;
    endproperty
    a_count_up: assert property (p_count_up) else $error("counter did not step");
    property p_div1;
        !halt_q && ps_q == 3'h0 |-> tick;
    endproperty
    a_div1: assert property (p_div1) else $error("divide-by-one not ticking");
endmodule // tcct_timer
`default_nettype wire

// File: test/tcct_pin_model.sv
// Far-side model: the external counter clock and the two channel pin wires.
// Assumes the bench chooses the far-side pin levels and when the clock runs.
`timescale 1ns/100ps
`default_nettype none
module tcct_pin_model (
    input wire logic ext_run, // Run the external clock
    input wire logic [1:0] drv_lvl, // Far-side level on each pin
    input wire logic [1:0] pin_out, // Timer drive level
    input wire logic [1:0] pin_oe, // Timer drive enable
    output logic ext_clk, // External counter clock
    output logic [1:0] pin_lvl // Resolved pin level
);
    // Stands low when stopped; the 64 ns period puts its edges on bus clock falling edges, never on rising ones
    always #32 ext_clk = ext_run ? ~ext_clk : 1'h0;
    assign pin_lvl = (pin_oe & pin_out) | (~pin_oe & drv_lvl);
endmodule // tcct_pin_model
`default_nettype wire

// File: test/tcct_timer_tb.sv
// Self-checking bench of the two-channel capture/compare timer.
// Assumes the design files and the pin model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
module tcct_timer_tb;
    logic clk = 1'h0;
    logic rstn = 1'h0;
    logic [7:0] addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'h0;
    logic rd = 1'h0;
    logic ext_run = 1'h0;
    logic [1:0] drv_lvl = 2'h3;
    logic [15:0] rdata_q;
    logic [1:0] pin_out;
    logic [1:0] pin_oe;
    logic [1:0] pin_lvl;
    logic ext_clk;
    logic irq_q;
    logic [15:0] rv;
    logic [15:0] rv2;
    int n_mismatch = 0;
    int check_count = 0;
    always #4 clk = ~clk;
    tcct_timer uut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata_q(rdata_q), .ext_timer_clock_pin(ext_clk), .channel_pin_in(pin_lvl),
        .channel_pin_out(pin_out), .channel_pin_oe(pin_oe), .irq_q(irq_q));
    tcct_pin_model far (.ext_run(ext_run), .drv_lvl(drv_lvl), .pin_out(pin_out),
        .pin_oe(pin_oe), .ext_clk(ext_clk), .pin_lvl(pin_lvl));
    task automatic wreg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge clk);
        wr <= 1'h0;
    endtask
    task automatic rreg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'h1;
        @(posedge clk);
        rd <= 1'h0;
        #1 rv = rdata_q;
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic t_flag;
        int i;
        rreg(tcct_pkg::A_STAT);
        `CHK("status_reset", 16'h0020, rv)
        wreg(tcct_pkg::A_STAT, 16'h00A0);
        rreg(tcct_pkg::A_STAT);
        `CHK("write_one_ignored", 16'h0020, rv)
        rreg(8'h07);
        `CHK("unmapped_read", 16'h0000, rv)
        `CHK("preset_high", 2'h3, pin_out)
        wreg(tcct_pkg::A_MOD, 16'h0004);
        wreg(tcct_pkg::A_STAT, 16'h0000);
        repeat (20) @(posedge clk);
        rreg(tcct_pkg::A_COUNT);
        `CHK("count_in_range", 1'h1, rv <= 16'h0004)
        wreg(tcct_pkg::A_STAT, 16'h00A0);
        wreg(tcct_pkg::A_STAT, 16'h0020);
        rreg(tcct_pkg::A_STAT);
        `CHK("flag_kept", 16'h00A0, rv)
        wreg(tcct_pkg::A_STAT, 16'h0020);
        rreg(tcct_pkg::A_STAT);
        `CHK("flag_cleared", 16'h0020, rv)
        rreg(tcct_pkg::A_COUNT);
        rv2 = rv;
        repeat (10) @(posedge clk);
        rreg(tcct_pkg::A_COUNT);
        `CHK("halted_count", rv2, rv)
        wreg(tcct_pkg::A_STAT, 16'h0000);
        repeat (10) @(posedge clk);
        rreg(tcct_pkg::A_STAT);
        repeat (10) @(posedge clk);
        wreg(tcct_pkg::A_STAT, 16'h0030);
        rreg(tcct_pkg::A_STAT);
        `CHK("wrap_beats_clear", 16'h00A0, rv)
        rreg(tcct_pkg::A_COUNT);
        `CHK("count_zeroed", 16'h0000, rv)
        wreg(tcct_pkg::A_STAT, 16'h0040);
        for (i = 0; i < 50 && irq_q !== 1'h1; i++) @(negedge clk);
        `CHK("irq_raised", 1'h1, irq_q)
        if (i == 50)
            report_and_stop();
        wreg(tcct_pkg::A_STAT, 16'h0060);
        rreg(tcct_pkg::A_STAT);
        wreg(tcct_pkg::A_STAT, 16'h0020);
        repeat (2) @(negedge clk);
        `CHK("irq_dropped", 1'h0, irq_q)
    endtask
    task automatic t_prescale;
        logic [15:0] exp;
        wreg(tcct_pkg::A_MOD, 16'hFFFF);
        ext_run <= 1'h1;
        for (int p = 0; p < 8; p++)
        begin
            wreg(tcct_pkg::A_STAT, 16'h0030 | 16'(p));
            wreg(tcct_pkg::A_STAT, 16'(p));
            rreg(tcct_pkg::A_COUNT);
            rv2 = rv;
            repeat (126) @(posedge clk);
            rreg(tcct_pkg::A_COUNT);
            exp = (p == 7) ? 16'h0010 : (16'h0080 >> p);
            `CHK("ticks_in_window", exp, rv - rv2)
        end
        wreg(tcct_pkg::A_STAT, 16'h0020);
        ext_run <= 1'h0;
    endtask
    task automatic t_capture;
        logic [15:0] c;
        drv_lvl <= 2'h0;
        for (int k = 1; k < 4; k++)
        begin
            c = 16'(k) << 2;
            wreg(tcct_pkg::A_STAT, 16'h0030);
            wreg(tcct_pkg::A_CH0_CTL, c);
            drv_lvl[0] <= 1'h1;
            repeat (6) @(posedge clk);
            drv_lvl[0] <= 1'h0;
            repeat (6) @(posedge clk);
            rreg(tcct_pkg::A_CH0_CTL);
            `CHK("halted_capture", 1'h0, rv[7])
            wreg(tcct_pkg::A_STAT, 16'h0000);
            drv_lvl[0] <= 1'h1;
            repeat (6) @(posedge clk);
            rreg(tcct_pkg::A_CH0_CTL);
            `CHK("capture_rise", c[2], rv[7])
            wreg(tcct_pkg::A_CH0_CTL, c);
            drv_lvl[0] <= 1'h0;
            repeat (6) @(posedge clk);
            rreg(tcct_pkg::A_CH0_CTL);
            `CHK("capture_fall", c[3], rv[7])
            wreg(tcct_pkg::A_CH0_CTL, c);
        end
    endtask
    task automatic t_compare;
        logic [7:0] cc [8] = '{8'h10, 8'h1C, 8'h18, 8'h14, 8'h2C, 8'h28, 8'h24, 8'h1E};
        logic [1:0] ex [8] = '{2'h0, 2'h1, 2'h0, 2'h2, 2'h1, 2'h0, 2'h2, 2'h2};
        logic s;
        wreg(tcct_pkg::A_MOD, 16'h0010);
        wreg(tcct_pkg::A_CH1_VAL, 16'h0008);
        for (int i = 0; i < 8; i++)
        begin
            wreg(tcct_pkg::A_STAT, 16'h0030);
            wreg(tcct_pkg::A_CH1_CTL, {8'h00, cc[i]});
            // Compare at the modulo value so the wrap and the match coincide
            if (i == 7)
                wreg(tcct_pkg::A_CH1_VAL, 16'h0010);
            wreg(tcct_pkg::A_STAT, 16'h0000);
            repeat (40) @(posedge clk);
            #1 s = pin_out[1];
            `CHK("drive_enable", cc[i][3:2] != 2'h0, pin_oe[1])
            if (ex[i] == 2'h2)
            begin
                repeat (17) @(posedge clk);
                #1 `CHK("toggle_level", ~s, pin_out[1])
            end
            else
                `CHK("compare_level", ex[i][0], s)
        end
        wreg(tcct_pkg::A_STAT, 16'h0020);
    endtask
    initial
    begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        report_and_stop();
    end
    initial
    begin
        repeat (20) @(posedge clk);
        rstn <= 1'h1;
        repeat (3) @(posedge clk);
        t_flag();
        t_prescale();
        t_capture();
        t_compare();
        report_and_stop();
    end
endmodule // tcct_timer_tb
`default_nettype wire
